// *** core/canctl_fifo.v ***
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock, synchronous active-high reset, clock enable.
 */
`timescale 1ns/10ps
module canctl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             ref_clk,   // clock
  input  wire             rst,       // sync reset
  input  wire             clk_en,    // freeze when low
  input  wire [WIDTH-1:0] in_data,   // write word
  input  wire             in_valid,  // write request
  output wire             in_ready,  // not full
  output wire [WIDTH-1:0] out_data,  // head word
  output wire             out_valid, // not empty
  input  wire             out_ready  // drain
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW:0]      wp;              // write pointer
  reg [AW:0]      rp;              // read pointer
  reg [WIDTH-1:0] head;            // combinational head
  wire            empty;           // no words
  assign empty     = (wp == rp);
  assign in_ready  = ((wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]));
  assign out_valid = !empty;
  assign out_data  = head;
  // ************************************************************
  // pointers and storage
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (in_valid && in_ready) begin // push
        mem[wp[AW-1:0]] <= in_data;
        wp <= wp + 1'b1;
      end
      if (out_valid && out_ready) // pop
        rp <= rp + 1'b1;
    end
  end
  // head word follows read pointer
  always @* begin
    head = mem[rp[AW-1:0]];
  end
endmodule

// *** core/canctl_top.v ***
/*
 * control, status, flag and error-count registers of a can controller, behind axi4-lite.
 * assumes the protocol engine drives the event, counter and bus-idle inputs on ref_clk.
 */
`timescale 1ns/10ps
`include "canctl_regs.vh"
// Notes on behaviour
// - loopback feeds internal tx into rx
// - loopback releases tx and rx pins
// - three-bit mode request, two codes reserved
// - mode report shows actual mode
// - mode changes only after eleven idle bits
// - capture event on receive when enabled
// - window bit selects filter or buffer map
// - data compare count, codes above 17 invalid
// - interrupt code names buffers 0 to 31
// - fifo start buffer field 0 to 31
// - flags cleared by writing zero
// - tx count high byte, rx low byte
// - quantum is two times prescaler plus one
// - jump width one to four quanta
module canctl_top #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire        ref_clk,      // 250 mhz clock
  input  wire        rst,          // sync reset, high
  input  wire        clk_en,       // freeze when low
  input  wire [7:0]  s_axi_awaddr, // write address
  input  wire        s_axi_awvalid,// write address valid
  output wire        s_axi_awready,// write address ready
  input  wire [31:0] s_axi_wdata,  // write data
  input  wire [3:0]  s_axi_wstrb,  // byte enables
  input  wire        s_axi_wvalid, // write data valid
  output wire        s_axi_wready, // write data ready
  output reg  [1:0]  s_axi_bresp,  // write response
  output reg         s_axi_bvalid, // write response valid
  input  wire        s_axi_bready, // write response ready
  input  wire [7:0]  s_axi_araddr, // read address
  input  wire        s_axi_arvalid,// read address valid
  output wire        s_axi_arready,// read address ready
  output reg  [31:0] s_axi_rdata,  // read data
  output reg  [1:0]  s_axi_rresp,  // read response
  output reg         s_axi_rvalid, // read data valid
  input  wire        s_axi_rready, // read data ready
  input  wire        bit_tick,     // one per nominal bit
  input  wire        bus_recessive,// sampled bus level recessive
  input  wire        tx_busy,      // transmission in progress
  input  wire        engine_tx,    // engine transmit bit
  output wire        engine_rx,    // engine receive bit
  output reg         can_tx_pin,   // bus transmit pin
  output reg         can_tx_oe,    // tx pin driven
  input  wire        can_rx_pin,   // bus receive pin
  output reg         can_rx_en,    // rx pin owned by module
  output wire        abort_req,    // abort pending tx
  input  wire        abort_done,   // all aborted
  input  wire        rx_done,      // message received pulse
  input  wire [31:0] rx_word,      // received data word
  output reg         capture_event,// timer capture pulse
  input  wire [4:0]  hit_filter,   // matched filter on rx_done
  input  wire [4:0]  hit_buffer,   // buffer of rx_done
  input  wire        tx_done,      // transmit done pulse
  input  wire [2:0]  tx_buffer,    // buffer of tx_done
  input  wire        ev_invalid,   // invalid message pulse
  input  wire        ev_wake,      // wakeup pulse
  input  wire        ev_error,     // error pulse
  input  wire        ev_fifo,      // fifo almost full pulse
  input  wire        ev_ovf,       // overflow pulse
  input  wire [7:0]  tx_err_cnt,   // transmit error count
  input  wire [7:0]  rx_err_cnt,   // receive error count
  output wire [7:0]  tq_periods,   // clocks per quantum
  output wire [2:0]  sjw_quanta,   // jump width in quanta
  output wire        filter_window,// filter map selected
  output wire [4:0]  compare_bits, // data compare count
  output wire [4:0]  fifo_start,   // fifo start buffer
  output wire        stop_idle     // stop in idle
);
  // ************************************************************
  // state
  // ************************************************************
  reg        stop_in_idle;           // stop in idle
  reg        abort_all_pending;      // abort request
  reg [2:0]  mode_request;           // requested mode
  reg [2:0]  mode_report;            // actual mode
  reg        rx_capture_event_enable;// capture enable
  reg        register_window_select; // map window
  reg [4:0]  data_compare_bit_count; // compare count
  reg [4:0]  fifo_start_buffer;      // fifo start
  reg [7:0]  flags;                  // interrupt flags
  reg [7:0]  enables;                // interrupt enables
  reg [7:0]  bit_timing;             // sjw and prescaler
  reg [4:0]  matched_filter_number;  // last hit filter
  reg [6:0]  interrupt_source_code;  // source code
  reg [5:0]  fifo_write_pointer;     // fifo write buffer
  reg [3:0]  idle_count;             // recessive bits seen
  reg        aw_held;                // address taken
  reg        w_held;                 // data taken
  reg [7:0]  aw_addr;                // held address
  reg [31:0] w_data;                 // held data
  reg [3:0]  w_strb;                 // held strobes
  wire       fifo_in_ready;          // rx fifo room
  wire [31:0] fifo_out_data;         // rx fifo head
  wire       fifo_out_valid;         // rx fifo has data
  wire       fifo_pop;               // read of data reg
  wire       do_write;               // write commit
  wire       loop_on;                // loopback active
  wire       pins_off;               // pins released
  wire [7:0] err_state;              // error state bits
  wire [7:0] ev_set;                 // flag set terms
  // ************************************************************
  // helpers
  // ************************************************************
  // mode code legal for request
  function legal_mode;
    input [2:0] m;
    begin
      legal_mode = (m != 3'h5) && (m != 3'h6);
    end
  endfunction
  // merge a 16-bit register with write strobes
  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction
  // ************************************************************
  // link muxing
  // ************************************************************
  assign loop_on  = (mode_report == `CANCTL_MODE_LOOP);
  assign pins_off = loop_on || (mode_report == `CANCTL_MODE_DISABLE) || (mode_report == `CANCTL_MODE_CONFIG);
  assign engine_rx = loop_on ? engine_tx : can_rx_pin;
  // pin drive registered
  always @(posedge ref_clk) begin
    if (rst) begin
      can_tx_pin <= 1'b1;
      can_tx_oe  <= 1'b0;
      can_rx_en  <= 1'b0;
    end else if (clk_en) begin
      can_tx_pin <= engine_tx;
      can_tx_oe  <= !pins_off && (mode_report != `CANCTL_MODE_LISTEN);
      can_rx_en  <= !pins_off;
    end
  end
  // ************************************************************
  // mode change after bus idle
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      idle_count  <= 4'h0;
      mode_report <= `CANCTL_MODE_CONFIG;
    end else if (clk_en) begin
      if (!bus_recessive || tx_busy)
        idle_count <= 4'h0;
      else if (bit_tick && idle_count != `CANCTL_IDLE_BITS)
        idle_count <= idle_count + 4'h1;
      if (mode_request != mode_report && idle_count == `CANCTL_IDLE_BITS)
        mode_report <= mode_request;
    end
  end
  // ************************************************************
  // capture, interrupt code, filter hit, fifo pointer
  // ************************************************************
  assign ev_set = {ev_invalid, ev_wake, ev_error, 1'b0, ev_fifo, ev_ovf, rx_done, tx_done};
  always @(posedge ref_clk) begin
    if (rst) begin
      capture_event         <= 1'b0;
      matched_filter_number <= 5'h00;
      interrupt_source_code <= `CANCTL_IC_NONE;
      fifo_write_pointer    <= 6'h00;
    end else if (clk_en) begin
      capture_event <= rx_done && rx_capture_event_enable;
      if (rx_done) begin
        matched_filter_number <= hit_filter;
        fifo_write_pointer    <= {1'b0, hit_buffer};
      end
      if (ev_error)
        interrupt_source_code <= `CANCTL_IC_ERR;
      else if (ev_wake)
        interrupt_source_code <= `CANCTL_IC_WAKE;
      else if (ev_ovf)
        interrupt_source_code <= `CANCTL_IC_OVF;
      else if (ev_fifo)
        interrupt_source_code <= `CANCTL_IC_FIFO;
      else if (rx_done)
        interrupt_source_code <= {2'b00, hit_buffer};
      else if (tx_done)
        interrupt_source_code <= {4'h0, tx_buffer};
    end
  end
  // ************************************************************
  // receive fifo
  // ************************************************************
  canctl_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_data   (rx_word),
    .in_valid  (rx_done),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );
  // ************************************************************
  // axi4-lite write path
  // ************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign abort_req     = abort_all_pending;
  always @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CANCTL_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `CANCTL_OFF_CTRL1, `CANCTL_OFF_FCTRL, `CANCTL_OFF_INTF,
          `CANCTL_OFF_INTE, `CANCTL_OFF_CFG1: s_axi_bresp <= `CANCTL_RESP_OKAY;
          default: s_axi_bresp <= `CANCTL_RESP_SLVERR; // read-only or unmapped
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ************************************************************
  // writable registers
  // ************************************************************
  always @(posedge ref_clk) begin : regs_wr
    reg [15:0] v;
    v = 16'h0000;
    if (rst) begin
      stop_in_idle            <= 1'b0;
      abort_all_pending       <= 1'b0;
      mode_request            <= `CANCTL_MODE_CONFIG;
      rx_capture_event_enable <= 1'b0;
      register_window_select  <= 1'b0;
      data_compare_bit_count  <= 5'h00;
      fifo_start_buffer       <= 5'h00;
      flags                   <= 8'h00;
      enables                 <= 8'h00;
      bit_timing              <= 8'h00;
    end else if (clk_en) begin
      if (abort_all_pending && abort_done)
        abort_all_pending <= 1'b0;
      if (do_write) begin
        case (aw_addr)
          `CANCTL_OFF_CTRL1: begin
            v = merge({2'b00, stop_in_idle, abort_all_pending, 1'b0, mode_request, 4'h0,
                       rx_capture_event_enable, 2'b00, register_window_select}, w_data, w_strb);
            stop_in_idle <= v[`CANCTL_CTRL1_SIDL];
            if (v[`CANCTL_CTRL1_ABORT_ALL_PENDING])
              abort_all_pending <= 1'b1;
            if (legal_mode(v[10:8]))
              mode_request <= v[10:8];
            rx_capture_event_enable <= v[`CANCTL_CTRL1_CAP];
            register_window_select  <= v[`CANCTL_CTRL1_WIN];
          end
          `CANCTL_OFF_FCTRL: begin
            v = merge({3'b000, data_compare_bit_count, 3'b000, fifo_start_buffer}, w_data, w_strb);
            if (v[12:8] <= `CANCTL_DATA_COMPARE_BIT_COUNT_MAX)
              data_compare_bit_count <= v[12:8];
            fifo_start_buffer <= v[4:0];
          end
          `CANCTL_OFF_INTE: begin
            v = merge({8'h00, enables}, w_data, w_strb);
            enables <= v[7:0] & 8'hef;
          end
          `CANCTL_OFF_CFG1: begin
            v = merge({8'h00, bit_timing}, w_data, w_strb);
            bit_timing <= v[7:0];
          end
          default: begin
            v = 16'h0000;
          end
        endcase
      end
      // flags: events set, write of zero clears, set wins
      if (do_write && aw_addr == `CANCTL_OFF_INTF && w_strb[0])
        flags <= ((flags & w_data[7:0]) | ev_set) & 8'hef;
      else
        flags <= (flags | ev_set) & 8'hef;
    end
  end
  // ************************************************************
  // derived outputs
  // ************************************************************
  assign tq_periods    = {1'b0, bit_timing[5:0], 1'b0} + 8'h02;
  assign sjw_quanta    = {1'b0, bit_timing[7:6]} + 3'h1;
  assign filter_window = register_window_select;
  assign compare_bits  = data_compare_bit_count;
  assign fifo_start    = fifo_start_buffer;
  assign stop_idle     = stop_in_idle;
  assign err_state = {2'b00, tx_err_cnt > 8'hff - 8'h00 ? 1'b1 : 1'b0, tx_err_cnt > 8'h7f,
                      rx_err_cnt > 8'h7f, tx_err_cnt > 8'h5f, rx_err_cnt > 8'h5f,
                      (tx_err_cnt > 8'h5f) || (rx_err_cnt > 8'h5f)};
  // ************************************************************
  // axi4-lite read path
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign fifo_pop      = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `CANCTL_OFF_RXDATA) && fifo_out_valid;
  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CANCTL_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CANCTL_RESP_OKAY;
        case (s_axi_araddr)
          `CANCTL_OFF_CTRL1: s_axi_rdata <= {18'h0, stop_in_idle, abort_all_pending, 1'b0, mode_request,
                                             mode_report, 1'b0, rx_capture_event_enable, 2'b00,
                                             register_window_select};
          `CANCTL_OFF_CTRL2: s_axi_rdata <= {27'h0, data_compare_bit_count};
          `CANCTL_OFF_VEC:   s_axi_rdata <= {19'h0, matched_filter_number, 1'b0, interrupt_source_code};
          `CANCTL_OFF_FCTRL: s_axi_rdata <= {19'h0, data_compare_bit_count, 3'b000, fifo_start_buffer};
          `CANCTL_OFF_FIFO:  s_axi_rdata <= {18'h0, fifo_write_pointer, 2'b00, 1'b0, fifo_start_buffer};
          `CANCTL_OFF_INTF:  s_axi_rdata <= {16'h0, err_state, flags};
          `CANCTL_OFF_INTE:  s_axi_rdata <= {24'h0, enables};
          `CANCTL_OFF_EC:    s_axi_rdata <= {16'h0, tx_err_cnt, rx_err_cnt};
          `CANCTL_OFF_CFG1:  s_axi_rdata <= {24'h0, bit_timing};
          `CANCTL_OFF_RXDATA: s_axi_rdata <= fifo_out_valid ? fifo_out_data : 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CANCTL_RESP_SLVERR; // unmapped
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** shared/canctl_regs.vh ***
/*
 * register offsets, field positions and reset values of the can control/status block.
 * assumes a 32-bit axi4-lite slave with one register per aligned word.
 */
`ifndef CANCTL_REGS_VH
`define CANCTL_REGS_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define CANCTL_OFF_CTRL1    8'h00
`define CANCTL_OFF_CTRL2    8'h04
`define CANCTL_OFF_VEC      8'h08
`define CANCTL_OFF_FCTRL    8'h0c
`define CANCTL_OFF_FIFO     8'h10
`define CANCTL_OFF_INTF     8'h14
`define CANCTL_OFF_INTE     8'h18
`define CANCTL_OFF_EC       8'h1c
`define CANCTL_OFF_CFG1     8'h20
`define CANCTL_OFF_RXDATA   8'h24
// ************************************************************
// field positions
// ************************************************************
`define CANCTL_CTRL1_SIDL   13
`define CANCTL_CTRL1_ABORT_ALL_PENDING   12
`define CANCTL_CTRL1_CAP    3
`define CANCTL_CTRL1_WIN    0
// ************************************************************
// reset values and codes
// ************************************************************
`define CANCTL_MODE_NORMAL  3'h0
`define CANCTL_MODE_DISABLE 3'h1
`define CANCTL_MODE_LOOP    3'h2
`define CANCTL_MODE_LISTEN  3'h3
`define CANCTL_MODE_CONFIG  3'h4
`define CANCTL_MODE_ALL     3'h7
`define CANCTL_IDLE_BITS    4'hb
`define CANCTL_DATA_COMPARE_BIT_COUNT_MAX    5'h11
`define CANCTL_IC_ERR       7'h41
`define CANCTL_IC_WAKE      7'h42
`define CANCTL_IC_OVF       7'h43
`define CANCTL_IC_FIFO      7'h44
`define CANCTL_IC_NONE      7'h40
`define CANCTL_RESP_OKAY    2'h0
`define CANCTL_RESP_SLVERR  2'h2
`endif

// *** verification/canctl_bus_model.sv ***
/* far-side bus model: bit timing and idle or busy bus.
   assumes ref_clk, sync high reset; four clocks per bit. */
`timescale 1ns/10ps
module canctl_bus_model (
  input  logic ref_clk,       // clock
  input  logic rst,           // sync reset
  input  logic quiet,         // bus left idle
  output logic bit_tick,      // one per bit
  output logic bus_recessive, // bus level
  output logic tx_busy        // frame under way
);
  logic [1:0] div; // clocks within a bit
  // free bit divider, the engine's bit clock
  always @(posedge ref_clk) begin
    if (rst) div <= 2'h0;
    else div <= div + 2'h1;
  end
  assign bit_tick = (div == 2'h3);
  // a busy bus shows dominant bits and a frame
  assign bus_recessive = quiet;
  assign tx_busy = !quiet;
endmodule

// *** verification/canctl_checker.sv ***
/* port checker for canctl_top.
   assumes a bind to canctl_top, one clock, sync high reset. */
`timescale 1ns/10ps
module canctl_checker (
  input logic        ref_clk,       // clock
  input logic        rst,           // sync reset
  input logic        s_axi_arvalid, // read address valid
  input logic        s_axi_arready, // read address ready
  input logic [1:0]  s_axi_bresp,   // write response
  input logic        s_axi_bvalid,  // write response valid
  input logic        s_axi_bready,  // write response ready
  input logic [31:0] s_axi_rdata,   // read data
  input logic        s_axi_rvalid,  // read data valid
  input logic        s_axi_rready,  // read data ready
  input logic        engine_rx,     // engine receive bit
  input logic        can_rx_pin,    // bus receive pin
  input logic        can_tx_oe,     // tx pin driven
  input logic        can_rx_en,     // rx pin owned
  input logic        abort_req,     // abort pending tx
  input logic        abort_done,    // all aborted
  input logic        rx_done,       // message received
  input logic        capture_event, // timer capture pulse
  input logic [7:0]  tq_periods,    // clocks per quantum
  input logic [2:0]  sjw_quanta,    // jump width
  input logic [4:0]  compare_bits   // data compare count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // write answer left waiting for the master
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  b_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  rx_route_a: assert property (can_rx_en |-> engine_rx == can_rx_pin) else $error("rx path wrong");
  pin_release_a: assert property (!can_rx_en |-> !can_tx_oe) else $error("tx pin kept");
  cap_cause_a: assert property (capture_event |-> $past(rx_done)) else $error("stray capture");
  tq_even_a: assert property (tq_periods[0] == 1'b0 && tq_periods != 7'h00) else $error("bad tq");
  sjw_range_a: assert property (sjw_quanta >= 3'h1 && sjw_quanta <= 3'h4) else $error("bad sjw");
  cmp_range_a: assert property (compare_bits <= 5'h11) else $error("bad count");
  abort_clr_a: assert property (abort_req && abort_done |-> ##[1:3] !abort_req) else $error("abort stuck");
endmodule
bind canctl_top canctl_checker u_chk (.ref_clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .engine_rx, .can_rx_pin, .can_tx_oe, .can_rx_en,
  .abort_req, .abort_done, .rx_done, .capture_event, .tq_periods, .sjw_quanta, .compare_bits);

// *** verification/tb.sv ***
/* self-checking bench for canctl_top.
   assumes canctl_bus_model and the checker bind. */
`timescale 1ns/10ps
`include "canctl_regs.vh"
`define CK(n,e,g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  typedef struct {bit wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} canctl_row_t;
  logic        ref_clk, rst, clk_en, quiet, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        bit_tick, bus_recessive, tx_busy, engine_tx, engine_rx, can_tx_pin, can_tx_oe, can_rx_pin;
  logic        can_rx_en, abort_req, abort_done, rx_done, capture_event, tx_done, ev_invalid, ev_wake;
  logic        ev_error, ev_fifo, ev_ovf, filter_window, stop_idle;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_err_cnt, rx_err_cnt;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx_word, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [4:0]  hit_filter, hit_buffer, compare_bits, fifo_start;
  logic [2:0]  tx_buffer, sjw_quanta;
  logic [7:0]  tq_periods;
  int          n_errors, n_compared, cyc;
  int          codes [6] = '{0, 1, 2, 3, 7, 4};
  canctl_row_t rows [15] = '{'{0,8'h00,0,32'h480,0}, '{0,8'h04,0,0,0}, '{0,8'h08,0,32'h40,0}, '{0,8'h1c,0,0,0},
    '{1,8'h20,32'hc5,0,0}, '{0,8'h20,0,32'hc5,0}, '{1,8'h18,32'hff,0,0}, '{0,8'h18,0,32'hef,0},
    '{1,8'h0c,32'h111f,0,0}, '{1,8'h0c,32'h121f,0,0}, '{0,8'h04,0,32'h11,0}, '{1,8'h1c,32'h1,0,2},
    '{0,8'h3c,0,0,2}, '{1,8'h00,32'h2409,0,0}, '{0,8'h00,0,32'h2489,0}};
  canctl_top u_dut (.*);
  canctl_bus_model u_bus (.ref_clk, .rst, .quiet, .bit_tick, .bus_recessive, .tx_busy);
  task conclude;
    $display("checks %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one write, both channels offered together
  task axw(input [7:0] a, input [31:0] d, output [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // one read, data taken at the handshake edge
  task axr(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task rc(input [7:0] a, input [31:0] e, input string n);
    axr(a, rd, rs);
    `CK(n, e, rd)
  endtask
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude;
    end
  end
  initial begin
    {rst, clk_en, quiet, s_axi_wstrb} = 7'h7f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, engine_tx, can_rx_pin} = '0;
    {abort_done, rx_done, tx_done, ev_invalid, ev_wake, ev_error, ev_fifo, ev_ovf} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_word, tx_err_cnt, rx_err_cnt} = '0;
    {hit_filter, hit_buffer, tx_buffer} = '0;
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    foreach (rows[i]) begin
      if (rows[i].wr) axw(rows[i].a, rows[i].d, rs);
      else rc(rows[i].a, rows[i].e, "rdata");
      `CK("resp", rows[i].r, rs)
    end
    `CK("tq", 7'h0c, tq_periods)
    `CK("sjw", 3'h4, sjw_quanta)
    `CK("fstart", 5'h1f, fifo_start)
    `CK("cmp", 5'h11, compare_bits)
    `CK("win", 1'b1, filter_window)
    `CK("sidl", 1'b1, stop_idle)
    $display("test registers done");
    quiet <= 0;
    axw(8'h00, 32'h0008, rs);
    repeat (80) @(posedge ref_clk);
    rc(8'h00, 32'h0088, "busy");
    quiet <= 1;
    foreach (codes[i]) begin
      axw(8'h00, {21'h0, 3'(codes[i]), 8'h08}, rs);
      repeat (64) @(posedge ref_clk);
      axr(8'h00, rd, rs);
      `CK("mode", 3'(codes[i]), rd[7:5])
      `CK("oe", (codes[i] == 0 || codes[i] == 7), can_tx_oe)
      `CK("rxen", !(codes[i] == 1 || codes[i] == 2 || codes[i] == 4), can_rx_en)
      engine_tx <= (codes[i] == 2);
      @(posedge ref_clk);
      #1 `CK("loop", (codes[i] == 2), engine_rx)
      engine_tx <= 0;
    end
    axw(8'h00, 32'h0508, rs);
    rc(8'h00, 32'h0488, "rsvd");
    `CK("win", 1'b0, filter_window)
    $display("test modes done");
    tx_buffer <= 3'h6;
    tx_done <= 1;
    @(posedge ref_clk);
    tx_done <= 0;
    rc(8'h08, 32'h06, "vec");
    {ev_invalid, ev_wake, ev_error, ev_fifo, ev_ovf} <= 5'h1f;
    @(posedge ref_clk);
    {ev_invalid, ev_wake, ev_error, ev_fifo, ev_ovf} <= 5'h00;
    rc(8'h14, 32'hed, "flags");
    rc(8'h08, 32'h41, "vec");
    axw(8'h14, 32'hff, rs);
    rc(8'h14, 32'hed, "flags");
    axw(8'h14, 32'h00, rs);
    rc(8'h14, 32'h00, "flags");
    rc(8'h08, 32'h41, "vec");
    $display("test flags done");
    hit_filter <= 5'h0f;
    hit_buffer <= 5'h0a;
    for (int i = 0; i < 32; i++) begin
      rx_word <= 32'hc0de0000 + 32'(i);
      rx_done <= 1;
      @(posedge ref_clk);
    end
    rx_done <= 0;
    for (int i = 0; i < 32; i++) rc(8'h24, 32'hc0de0000 + 32'(i), "fifo");
    rc(8'h08, 32'h0f0a, "vec");
    $display("test fifo done");
    tx_err_cnt <= 8'h81;
    rx_err_cnt <= 8'h60;
    rc(8'h1c, 32'h8160, "ec");
    rc(8'h14, 32'h1702, "state");
    axw(8'h00, 32'h1408, rs);
    `CK("abort", 1'b1, abort_req)
    abort_done <= 1;
    @(posedge ref_clk);
    abort_done <= 0;
    repeat (3) @(posedge ref_clk);
    rc(8'h00, 32'h0488, "abort");
    $display("test errors done");
    conclude;
  end
endmodule
